// ### src/ppt_pkg.sv
// Shared types and constants of the encoder pattern position tracker.
// Assumes one 10 MHz clock and a synchronous active-low reset around it.
package ppt_pkg;

  localparam int CLK_HZ = 10_000_000;
  localparam int IDX_W = 16;
  localparam int FRAC_W = 12;
  localparam int ANG_W = IDX_W + FRAC_W;
  localparam int ACC_W = 24;
  localparam int DIV_STEPS = ACC_W + 1;
  localparam logic [IDX_W-1:0] IDX_RST = 16'h0000;
  localparam logic [ACC_W-1:0] PERIOD_RST = 24'h000000;
  localparam logic [ACC_W:0] RATE_RST = 25'h0000000;
  localparam logic [4:0] DIV_RST = 5'h00;

  typedef enum logic [1:0] {
    PPT_HUNT,
    PPT_ARMED,
    PPT_SYNC
  } ppt_state_type;

  typedef struct packed {
    logic tooth_input;
    logic reference_input;
  } ppt_sensor_input_bundle_type;

  typedef struct packed {
    logic [IDX_W-1:0] teeth_per_revolution;
    logic cycle_720;
    logic early_reference_error_clear;
    logic late_reference_error_clear;
  } ppt_tracker_controls_type;

  typedef struct packed {
    logic in_sync;
    logic tooth_edge;
    logic [IDX_W-1:0] tooth_index;
    logic [ANG_W-1:0] angle_position;
    logic [ACC_W-1:0] tooth_period;
    logic early_reference_error;
    logic late_reference_error;
  } ppt_tracker_outputs_type;

  typedef struct packed {
    logic in_sync;
    logic tooth_edge;
    logic cycle_720;
    logic [IDX_W-1:0] teeth_per_cycle;
    logic [ANG_W-1:0] angle_position;
  } ppt_actuator_supervision_bundle_type;

  // Highest tooth index of one tracked cycle.
  function automatic logic [IDX_W-1:0] ppt_max_index(input logic [IDX_W-1:0] n,
                                                     input logic c720);
    logic [IDX_W-1:0] span;
    span = c720 ? {n[IDX_W-2:0], 1'b0} : n;
    return span - 16'h0001;
  endfunction : ppt_max_index

endpackage : ppt_pkg

// ### src/ppt_tracker.sv
// Encoder pattern position tracker: tooth index, interpolated angle, sync and errors.
// Assumes tooth and reference pins are asynchronous and controls are on clk.
//
// Contract
// - Zero index and angle at first tooth after reference.
// - Select chooses 360 or 720 degree cycle.
// - Interpolate angle to a tenth degree or finer.
// - Early reference sets error and drops sync.
// - Early error clears on control; blocks re-sync.
// - Missing reference sets late error, drops sync.
// - Late error clears on control; blocks re-sync.
// - Single clock datapath samples inputs every cycle.
// - Output supervision bundle for fuel and spark.
`timescale 1ns/1ps
module ppt_tracker
  import ppt_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Sensor pins and configuration.
  input wire ppt_sensor_input_bundle_type sensor_input_bundle,
  input wire ppt_tracker_controls_type tracker_controls,
  // Results.
  output ppt_tracker_outputs_type tracker_outputs,
  output ppt_actuator_supervision_bundle_type actuator_supervision_bundle
);

  logic tooth_s1_q, tooth_s2_q, tooth_s3_q;
  logic ref_s1_q, ref_s2_q, ref_s3_q;
  logic tooth_rise, ref_rise;
  ppt_state_type state_q;
  logic [IDX_W-1:0] tooth_index_q;
  logic [IDX_W-1:0] max_index;
  logic ref_seen_q;
  logic early_q, late_q;
  logic early_set, late_set;
  logic [ACC_W-1:0] period_q, last_period_q, divisor_q;
  logic [ACC_W:0] rate_q, quot_q, rem_q;
  logic [4:0] div_cnt_q;
  logic [ACC_W-1:0] frac_acc_q;
  logic [ACC_W+1:0] frac_sum;
  logic [ACC_W:0] rem_shift;
  logic in_sync;

  // Both sensor pins are sampled on every rising edge through two flops before use.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tooth_s1_q <= 1'b0;
      tooth_s2_q <= 1'b0;
      tooth_s3_q <= 1'b0;
      ref_s1_q <= 1'b0;
      ref_s2_q <= 1'b0;
      ref_s3_q <= 1'b0;
    end else begin
      tooth_s1_q <= sensor_input_bundle.tooth_input;
      tooth_s2_q <= tooth_s1_q;
      tooth_s3_q <= tooth_s2_q;
      ref_s1_q <= sensor_input_bundle.reference_input;
      ref_s2_q <= ref_s1_q;
      ref_s3_q <= ref_s2_q;
    end
  end

  assign tooth_rise = tooth_s2_q & ~tooth_s3_q;
  assign ref_rise = ref_s2_q & ~ref_s3_q;
  assign max_index = ppt_max_index(tracker_controls.teeth_per_revolution,
                                   tracker_controls.cycle_720);
  assign in_sync = (state_q == PPT_SYNC);

  // The reference is legal only while the index sits on the last tooth.
  assign early_set = in_sync && ref_rise && (tooth_index_q != max_index);
  assign late_set = in_sync && tooth_rise && (tooth_index_q == max_index)
                    && !ref_seen_q && !ref_rise;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= PPT_HUNT;
    end else begin
      unique case (state_q)
        PPT_HUNT: begin
          if (ref_rise && !early_q && !late_q) begin
            state_q <= PPT_ARMED;
          end
        end
        PPT_ARMED: begin
          if (tooth_rise) begin
            state_q <= PPT_SYNC;
          end
        end
        PPT_SYNC: begin
          if (early_set || late_set) begin
            state_q <= PPT_HUNT;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tooth_index_q <= IDX_RST;
      ref_seen_q <= 1'b0;
    end else if (state_q == PPT_ARMED && tooth_rise) begin
      tooth_index_q <= IDX_RST;
      ref_seen_q <= 1'b0;
    end else if (in_sync) begin
      if (tooth_rise) begin
        tooth_index_q <= (tooth_index_q == max_index) ? IDX_RST
                         : tooth_index_q + 16'h0001;
        ref_seen_q <= 1'b0;
      end else if (ref_rise) begin
        ref_seen_q <= 1'b1;
      end
    end
  end

  // A new error in the clearing cycle wins over the clear.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      early_q <= 1'b0;
      late_q <= 1'b0;
    end else begin
      early_q <= early_set | (early_q & ~tracker_controls.early_reference_error_clear);
      late_q <= late_set | (late_q & ~tracker_controls.late_reference_error_clear);
    end
  end

  // Tooth period in clocks, saturating so a stopped wheel cannot wrap.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      period_q <= PERIOD_RST;
      last_period_q <= PERIOD_RST;
    end else if (tooth_rise) begin
      period_q <= 24'h000001;
      last_period_q <= period_q;
    end else if (period_q != 24'hffffff) begin
      period_q <= period_q + 24'h000001;
    end
  end

  // Serial divider gives the per-clock fraction step 2^24 / period. It takes
  // 25 clocks, so teeth 25 clocks apart or closer keep the previous step.
  assign rem_shift = {rem_q[ACC_W-1:0], (div_cnt_q == DIV_STEPS[4:0])};
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_cnt_q <= DIV_RST;
      divisor_q <= PERIOD_RST;
      rem_q <= RATE_RST;
      quot_q <= RATE_RST;
      rate_q <= RATE_RST;
    end else if (tooth_rise && div_cnt_q == DIV_RST && period_q != PERIOD_RST) begin
      div_cnt_q <= DIV_STEPS[4:0];
      divisor_q <= period_q;
      rem_q <= RATE_RST;
      quot_q <= RATE_RST;
    end else if (div_cnt_q != DIV_RST) begin
      div_cnt_q <= div_cnt_q - 5'h01;
      if (rem_shift >= {1'b0, divisor_q}) begin
        rem_q <= rem_shift - {1'b0, divisor_q};
        quot_q <= {quot_q[ACC_W-1:0], 1'b1};
      end else begin
        rem_q <= rem_shift;
        quot_q <= {quot_q[ACC_W-1:0], 1'b0};
      end
      if (div_cnt_q == 5'h01) begin
        rate_q <= (rem_shift >= {1'b0, divisor_q}) ? {quot_q[ACC_W-1:0], 1'b1}
                  : {quot_q[ACC_W-1:0], 1'b0};
      end
    end
  end

  // Fraction of a tooth in 1/4096 steps: 0.1 degree or finer for any count.
  assign frac_sum = {1'b0, frac_acc_q} + {1'b0, rate_q};
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      frac_acc_q <= PERIOD_RST;
    end else if (tooth_rise || !in_sync) begin
      frac_acc_q <= PERIOD_RST;
    end else if (frac_sum[ACC_W+1:ACC_W] != 2'b00) begin
      frac_acc_q <= 24'hffffff;
    end else begin
      frac_acc_q <= frac_sum[ACC_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tracker_outputs <= '0;
      actuator_supervision_bundle <= '0;
    end else begin
      tracker_outputs.in_sync <= in_sync;
      tracker_outputs.tooth_edge <= tooth_rise & in_sync;
      tracker_outputs.tooth_index <= tooth_index_q;
      tracker_outputs.angle_position <= {tooth_index_q, frac_acc_q[ACC_W-1 -: FRAC_W]};
      tracker_outputs.tooth_period <= last_period_q;
      tracker_outputs.early_reference_error <= early_q;
      tracker_outputs.late_reference_error <= late_q;
      actuator_supervision_bundle.in_sync <= in_sync;
      actuator_supervision_bundle.tooth_edge <= tooth_rise & in_sync;
      actuator_supervision_bundle.cycle_720 <= tracker_controls.cycle_720;
      actuator_supervision_bundle.teeth_per_cycle <= max_index + 16'h0001;
      actuator_supervision_bundle.angle_position <=
        {tooth_index_q, frac_acc_q[ACC_W-1 -: FRAC_W]};
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sync_zero_start_a: assert property (
    state_q == PPT_ARMED && tooth_rise |=> in_sync && tooth_index_q == IDX_RST
    && frac_acc_q == PERIOD_RST) else $error("Sync did not start at zero.");
  index_in_range_a: assert property (
    in_sync |-> tooth_index_q <= max_index) else $error("Tooth index beyond cycle.");
  early_sets_a: assert property (
    early_set |=> early_q && state_q == PPT_HUNT) else $error("Early reference missed.");
  early_clear_a: assert property (
    tracker_controls.early_reference_error_clear && !early_set |=> !early_q)
    else $error("Early error not cleared.");
  early_blocks_a: assert property (
    state_q == PPT_HUNT && early_q |=> state_q == PPT_HUNT)
    else $error("Re-sync with early error set.");
  late_sets_a: assert property (
    in_sync && tooth_rise && tooth_index_q == max_index && !ref_seen_q && !ref_rise
    |=> late_q && !in_sync) else $error("Late reference missed.");
  late_clear_a: assert property (
    tracker_controls.late_reference_error_clear && !late_set |=> !late_q)
    else $error("Late error not cleared.");
  late_blocks_a: assert property (
    state_q == PPT_HUNT && late_q |=> state_q == PPT_HUNT)
    else $error("Re-sync with late error set.");
  index_steps_a: assert property (
    in_sync && tooth_rise && tooth_index_q != max_index && !early_set
    |=> tooth_index_q == $past(tooth_index_q) + 16'h0001) else $error("Index did not step.");
  error_holds_a: assert property (
    early_q && !tracker_controls.early_reference_error_clear |=> early_q)
    else $error("Early error dropped without clear.");
  frac_rises_a: assert property (
    in_sync && !tooth_rise && $past(in_sync) |=> frac_acc_q >= $past(frac_acc_q))
    else $error("Interpolated fraction went backwards.");
  bundle_follows_a: assert property (
    ##1 actuator_supervision_bundle.in_sync == $past(in_sync))
    else $error("Supervision sync flag lags.");

  reach_sync_c: cover property (state_q == PPT_ARMED ##1 in_sync);
  early_error_c: cover property (early_set);
  cycle_wrap_c: cover property (in_sync && tooth_rise && tooth_index_q == max_index
                                && ref_seen_q);

endmodule : ppt_tracker

// ### test/ppt_sensor_model.sv
// Behavioural crank tooth and reference sensor model for the tracker bench.
// Assumes span and period stay fixed while run is high.
`timescale 1ns/1ps
module ppt_sensor_model
  import ppt_pkg::*;
(
  // Clock and run control.
  input wire logic clk,
  input wire logic run,
  // Pattern shape.
  input wire logic [IDX_W-1:0] span,
  input wire logic [7:0] period,
  // Faults on request.
  input wire logic skip_ref,
  input wire logic early_ref,
  // Sensor pins.
  output ppt_sensor_input_bundle_type pins
);
  logic [7:0] cnt_q = 8'h00;
  logic [IDX_W-1:0] idx_q = 16'h0000;
  logic tooth_q = 1'b0;
  logic ref_n_q = 1'b1;
  logic mid;
  logic last;
  // The cam sensor marks the cycle low, so it is inverted to give a rise.
  assign pins = {tooth_q, ~ref_n_q};
  // Reference starts as the last tooth falls, about half a period clear of either tooth rise.
  assign mid = (cnt_q >= (period >> 1)) && (cnt_q < (period >> 1) + 8'h03);
  assign last = (idx_q == span - 16'h0001);
  always @(posedge clk) begin
    if (!run) begin
      cnt_q <= 8'h00;
      idx_q <= span - 16'h0001;
      tooth_q <= 1'b0;
      ref_n_q <= 1'b1;
    end else begin
      cnt_q <= (cnt_q == period - 8'h01) ? 8'h00 : cnt_q + 8'h01;
      tooth_q <= (cnt_q < (period >> 1));
      if (cnt_q == period - 8'h01) begin
        idx_q <= last ? 16'h0000 : idx_q + 16'h0001;
      end
      ref_n_q <= !(mid && ((last && !skip_ref) || (idx_q == 16'h0001 && early_ref)));
    end
  end
endmodule : ppt_sensor_model

// ### test/testbench.sv
// Self-checking bench for the position tracker with a behavioural sensor model.
// Assumes the tracker's registered outputs settle before the falling edge.
`timescale 1ns/1ps
module testbench;
  import ppt_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic run = 1'b0;
  logic skip_ref = 1'b0;
  logic early_ref = 1'b0;
  logic [7:0] period = 8'h18;
  logic [15:0] n = 16'h0008;
  logic c720 = 1'b0;
  logic clr_e = 1'b0;
  logic clr_l = 1'b0;
  logic sync_seen = 1'b0;
  logic [15:0] last_idx = 16'h0000;
  logic [11:0] last_frac = 12'h000;
  int teeth = 0;
  int n_mismatch = 0;
  int tests_run = 0;
  int cycles = 0;
  int seed;
  ppt_sensor_input_bundle_type sens;
  ppt_tracker_controls_type ctl;
  ppt_tracker_outputs_type outs;
  ppt_actuator_supervision_bundle_type sup;

  function automatic logic [15:0] span_of(input logic [15:0] t, input logic c);
    return c ? {t[14:0], 1'b0} : t;
  endfunction : span_of

  function automatic logic flag(input int w);
    return (w == 0) ? outs.in_sync : (w == 1) ? outs.early_reference_error
                                               : outs.late_reference_error;
  endfunction : flag

  assign ctl = {n, c720, clr_e, clr_l};
  always #50 clk = ~clk;

  ppt_sensor_model model (.clk(clk), .run(run), .span(span_of(n, c720)), .period(period),
                          .skip_ref(skip_ref), .early_ref(early_ref), .pins(sens));
  ppt_tracker dut (.clk(clk), .rst_n(rst_n), .sensor_input_bundle(sens),
                   .tracker_controls(ctl), .tracker_outputs(outs),
                   .actuator_supervision_bundle(sup));

  task automatic complete_run();
    if (n_mismatch == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask : check

  task automatic wait_flag(input int w, input logic v, input int limit);
    for (int k = 0; k < limit && flag(w) !== v; k++) @(negedge clk);
  endtask : wait_flag

  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_mismatch++;
      complete_run();
    end
  end

  // Index and angle follow every counted tooth once sync is held.
  always @(negedge clk) begin
    if (rst_n && outs.in_sync === 1'b1 && !sync_seen) begin
      check("sync_index", 32'h0, outs.tooth_index);
      check("sync_angle", 32'h0, outs.angle_position);
      check("sup_sync", 32'h1, sup.in_sync);
      last_idx = 16'h0000;
      teeth = 0;
    end else if (rst_n && outs.in_sync === 1'b1 && outs.tooth_edge === 1'b1) begin
      // The edge pulse still shows the index of the tooth just left; the step follows.
      check("tooth_index", last_idx, outs.tooth_index);
      check("angle_whole", last_idx, outs.angle_position[27:12]);
      check("sup_angle", last_idx, sup.angle_position[27:12]);
      check("sup_edge", 32'h1, sup.tooth_edge);
      check("sup_span", span_of(n, c720), sup.teeth_per_cycle);
      if (teeth > 2) check("frac_end", 32'h1, last_frac >= 12'hc00);
      if (teeth > 2) check("tooth_period", period, outs.tooth_period);
      last_idx = (last_idx + 16'h0001 == span_of(n, c720)) ? 16'h0000 : last_idx + 16'h0001;
      teeth++;
    end
    sync_seen = rst_n && (outs.in_sync === 1'b1);
    last_frac = outs.angle_position[11:0];
  end

  initial begin
    seed = $urandom(30425);
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    @(negedge clk);
    check("rst_sync", 32'h0, outs.in_sync);
    check("rst_errors", 32'h0, {outs.early_reference_error, outs.late_reference_error});
    for (int i = 0; i < 3; i++) begin
      // The pattern is changed only under reset, so no stale index meets a new span.
      @(posedge clk);
      #1 run = 1'b0;
      rst_n = 1'b0;
      n = 16'h0004 + 16'($urandom % 9);
      c720 = (i < 2) ? i[0] : 1'($urandom % 2);
      period = 8'h14 + 8'($urandom % 20);
      repeat (3) @(posedge clk);
      #1 rst_n = 1'b1;
      run = 1'b1;
      @(negedge clk);
      check("rst_again", 32'h0, {outs.in_sync, outs.early_reference_error,
                                 outs.late_reference_error});
      wait_flag(0, 1'b1, 4 * int'(span_of(n, c720)) * period);
      check("in_sync", 32'h1, outs.in_sync);
      repeat (2 * int'(span_of(n, c720)) * period) @(posedge clk);
      check("sup_c720", c720, sup.cycle_720);
    end
    for (int e = 0; e < 2; e++) begin
      @(posedge clk);
      #1 skip_ref = (e == 0);
      early_ref = (e == 1);
      wait_flag(2 - e, 1'b1, 2 * int'(span_of(n, c720)) * period + 100);
      check("error_set", 32'h1, flag(2 - e));
      check("sync_lost", 32'h0, outs.in_sync);
      check("other_error", 32'h0, flag(1 + e));
      @(posedge clk);
      #1 skip_ref = 1'b0;
      early_ref = 1'b0;
      repeat (2 * int'(span_of(n, c720)) * period) @(posedge clk);
      check("held_error", 32'h1, flag(2 - e));
      check("no_resync", 32'h0, outs.in_sync);
      #1 clr_l = (e == 0);
      clr_e = (e == 1);
      @(posedge clk);
      #1 clr_l = 1'b0;
      clr_e = 1'b0;
      wait_flag(2 - e, 1'b0, 10);
      check("error_clear", 32'h0, flag(2 - e));
      wait_flag(0, 1'b1, 2 * int'(span_of(n, c720)) * period + 100);
      check("resync", 32'h1, outs.in_sync);
      repeat (int'(span_of(n, c720)) * period) @(posedge clk);
    end
    complete_run();
  end
endmodule : testbench
